// File: hdl/bpa_defs.vh
// Register offsets, reset values and widths for the analog-select GPIO port
`ifndef BPA_DEFS_VH
`define BPA_DEFS_VH

`define BPA_ADDR_W        12
`define BPA_OFF_PORT_DATA 12'h000
`define BPA_OFF_DIRECTION 12'h004
`define BPA_OFF_LATCH     12'h008
`define BPA_OFF_ANALOG    12'h00C

`define BPA_RST_DIRECTION 8'hFF
`define BPA_RST_LATCH     8'h00
`define BPA_RST_ANALOG    8'hFF
`define BPA_ZERO_BYTE     8'h00
`define BPA_ZERO_WORD     32'h0000_0000
`define BPA_UPPER_ZERO    24'h00_0000

`define BPA_PIN_SIX       6

`endif

// File: hdl/bpa_port.v
// Eight-pin bidirectional port with analog select, behind an APB slave
//
// Overview of operation
// RQ1 - Eight pins, each usable as digital input or driven digital output.
// RQ2 - Direction bit one turns the pin driver off, pin is an input.
// RQ3 - Direction bit zero enables the driver, pin shows the latch bit.
// RQ4 - Port data reads return pin levels; writes land in the output latch.
// RQ5 - Port data writes sample pins, modify addressed bits, store to latch.
// RQ6 - Direction bits still control drivers while a pin is analog.
// RQ7 - Software should keep analog pins set as inputs.
// RQ8 - Analog-selected pins read zero digitally and connect analog functions.
// RQ9 - Analog select never changes digital output driving.
// RQ10 - Every analog-select bit resets to analog.
// RQ11 - Software clears analog select before digital or peripheral input use.
// RQ12 - Highest-priority enabled output function controls a shared pin.
// RQ13 - Analog inputs connect only while the pin is in analog mode.
// RQ14 - Digital output functions drive analog-mode pins with same priority.
// RQ15 - Priority runs high to low, latch output always lowest.
// RQ16 - Pin six: regulator cap, crystal, clock out, LCD segment, latch.
// RQ17 - Register writes take effect on the edge completing the APB access.
`timescale 1ns/100ps
`include "bpa_defs.vh"

module bpa_port #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    input  wire [3:0]       pstrb,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out,
    output reg  [WIDTH-1:0] pin_oe,
    input  wire [WIDTH-1:0] periph_out_en,
    input  wire [WIDTH-1:0] periph_out_val,
    input  wire             regulator_capacitor_en,
    input  wire             crystal_output_en,
    input  wire             crystal_output_val,
    input  wire             clock_output_pin_en,
    input  wire             clock_output_pin_val,
    input  wire             lcd_segment_one_en,
    input  wire             lcd_segment_one_val,
    output reg  [WIDTH-1:0] digital_in,
    output reg  [WIDTH-1:0] analog_connect
);

    // Synchroniser stages and software-visible state
    reg  [WIDTH-1:0] sync1_reg;
    reg  [WIDTH-1:0] sync2_reg;
    reg  [WIDTH-1:0] pin_direction_bits_reg;
    reg  [WIDTH-1:0] pin_direction_bits_next;
    reg  [WIDTH-1:0] output_data_latch_reg;
    reg  [WIDTH-1:0] output_data_latch_next;
    reg  [WIDTH-1:0] analog_select_bits_reg;
    reg  [WIDTH-1:0] analog_select_bits_next;
    reg  [WIDTH-1:0] rd_byte;
    reg              rd_hit;
    reg              pready_next;
    reg              pslverr_next;
    reg  [31:0]      prdata_next;
    wire [WIDTH-1:0] pin_out_next;
    wire [WIDTH-1:0] pin_oe_next;
    wire [WIDTH-1:0] port_pin_data;
    wire             setup_ph;
    wire             wr_done;
    wire             sel_port;
    wire             sel_dir;
    wire             sel_latch;
    wire             sel_analog;
    wire             lane0;

    // Address decode, shared by reads and writes
    assign sel_port   = (paddr == `BPA_OFF_PORT_DATA);
    assign sel_dir    = (paddr == `BPA_OFF_DIRECTION);
    assign sel_latch  = (paddr == `BPA_OFF_LATCH);
    assign sel_analog = (paddr == `BPA_OFF_ANALOG);
    assign lane0      = pstrb[0];

    // Setup phase starts the access; the write commits when it completes
    assign setup_ph = psel & ~penable;
    assign wr_done  = psel & penable & pready & pwrite & ~pslverr; // [RQ17]

    // First synchroniser stage: raw pin levels, may go metastable
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync1_reg <= {WIDTH{1'b0}};
        else
            sync1_reg <= pin_in;
    end

    // Second stage: the only reader of the first
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync2_reg <= {WIDTH{1'b0}};
        else
            sync2_reg <= sync1_reg;
    end

    // Digital view of the pins; analog pins read zero
    assign port_pin_data = sync2_reg & ~analog_select_bits_reg; // [RQ8] [RQ4]

    // Read decode; an unmapped offset answers with an error and zero data
    // so that a stray access cannot be mistaken for a register
    always @*
    begin
        rd_byte = {WIDTH{1'b0}};
        rd_hit  = 1'b1;
        if (sel_port)
            rd_byte = port_pin_data; // [RQ4]
        else if (sel_dir)
            rd_byte = pin_direction_bits_reg;
        else if (sel_latch)
            rd_byte = output_data_latch_reg;
        else if (sel_analog)
            rd_byte = analog_select_bits_reg;
        else
            rd_hit = 1'b0;
    end

    // Response for the next access cycle: ready follows every setup phase
    always @*
    begin
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        prdata_next  = `BPA_ZERO_WORD;
        if (setup_ph)
        begin
            pready_next  = 1'b1;
            pslverr_next = ~rd_hit;
            if (!pwrite)
                prdata_next = {`BPA_UPPER_ZERO, rd_byte};
        end
    end

    // Ready stands for exactly the one access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= pready_next;
    end

    // Error flag stands beside ready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= pslverr_next;
    end

    // Read data is zero outside the access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= `BPA_ZERO_WORD;
        else
            prdata <= prdata_next;
    end

    // Direction write honours the low byte lane
    always @*
    begin
        pin_direction_bits_next = pin_direction_bits_reg;
        if (wr_done && lane0 && sel_dir)
            pin_direction_bits_next = pwdata[WIDTH-1:0];
    end

    // Analog-select write honours the low byte lane
    always @*
    begin
        analog_select_bits_next = analog_select_bits_reg;
        if (wr_done && lane0 && sel_analog)
            analog_select_bits_next = pwdata[WIDTH-1:0];
    end

    // Latch writes: direct through its own offset, read-modify-write
    // through the port data offset, where the pins are sampled first.
    // With the lane off the sampled pins are stored, so a pin held by an
    // outside source copies that level into the latch; a pin set analog stores zero.
    always @*
    begin
        output_data_latch_next = output_data_latch_reg;
        if (wr_done)
        begin
            if (sel_port)
            begin
                if (lane0)
                    output_data_latch_next = pwdata[WIDTH-1:0]; // [RQ5]
                else
                    output_data_latch_next = port_pin_data; // [RQ5]
            end
            else if (sel_latch && lane0)
                output_data_latch_next = pwdata[WIDTH-1:0];
        end
    end

    // Direction bits: all pins start as inputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_direction_bits_reg <= `BPA_RST_DIRECTION;
        else
            pin_direction_bits_reg <= pin_direction_bits_next; // [RQ17]
    end

    // Output latch
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            output_data_latch_reg <= `BPA_RST_LATCH;
        else
            output_data_latch_reg <= output_data_latch_next; // [RQ17]
    end

    // Analog-select bits: every pin starts analog
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            analog_select_bits_reg <= `BPA_RST_ANALOG; // [RQ10]
        else
            analog_select_bits_reg <= analog_select_bits_next; // [RQ17]
    end

    // Output priority per pin, highest first; the latch always comes last
    // and analog select takes no part, so analog pins still drive
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_pin
            if (g == `BPA_PIN_SIX)
            begin : g_six
                // Pin six ignores the generic peripheral request
                reg six_oe;
                reg six_val;
                always @*
                begin
                    if (regulator_capacitor_en) // [RQ16]
                    begin
                        // Capacitor pin: driver stays off
                        six_oe  = 1'b0;
                        six_val = 1'b0;
                    end
                    else if (crystal_output_en) // [RQ16]
                    begin
                        six_oe  = 1'b1;
                        six_val = crystal_output_val;
                    end
                    else if (clock_output_pin_en) // [RQ16]
                    begin
                        six_oe  = 1'b1;
                        six_val = clock_output_pin_val;
                    end
                    else if (lcd_segment_one_en) // [RQ16] [RQ12]
                    begin
                        six_oe  = 1'b1;
                        six_val = lcd_segment_one_val;
                    end
                    else
                    begin
                        // Latch last [RQ15]
                        six_oe  = ~pin_direction_bits_reg[g]; // [RQ2] [RQ3]
                        six_val = output_data_latch_reg[g];
                    end
                end
                assign pin_oe_next[g]  = six_oe;
                assign pin_out_next[g] = six_val;
            end
            else
            begin : g_gen
                reg gen_oe;
                reg gen_val;
                always @*
                begin
                    if (periph_out_en[g]) // [RQ12] [RQ14]
                    begin
                        gen_oe  = 1'b1;
                        gen_val = periph_out_val[g];
                    end
                    else
                    begin
                        // Direction alone gates the driver [RQ6] [RQ9] [RQ15]
                        gen_oe  = ~pin_direction_bits_reg[g]; // [RQ2] [RQ3]
                        gen_val = output_data_latch_reg[g];
                    end
                end
                assign pin_oe_next[g]  = gen_oe;
                assign pin_out_next[g] = gen_val;
            end
        end
    endgenerate

    // Pin drive levels
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_out <= `BPA_ZERO_BYTE;
        else
            pin_out <= pin_out_next; // [RQ1]
    end

    // Pin driver enables, high while the port drives the pin
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_oe <= `BPA_ZERO_BYTE;
        else
            pin_oe <= pin_oe_next;
    end

    // Digital input view for peripherals, analog pins held at zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            digital_in <= `BPA_ZERO_BYTE;
        else
            digital_in <= port_pin_data; // [RQ8]
    end

    // Analog input functions connect only on analog-selected pins
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            analog_connect <= `BPA_ZERO_BYTE;
        else
            analog_connect <= analog_select_bits_reg; // [RQ13]
    end

endmodule

// File: verif/bpa_pin_model.sv
// External circuitry model facing the eight port pins
`timescale 1ns/100ps
module bpa_pin_model (
    input  logic [7:0] pin_out,
    input  logic [7:0] pin_oe,
    input  logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // Released pins show the outside source, driven pins the port
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// File: verif/bpa_port_assertions.sv
// Port-level assertions for the analog-select GPIO port
`timescale 1ns/100ps
module bpa_port_chk (
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic       pslverr,
    input logic [7:0] pin_out,
    input logic [7:0] pin_oe,
    input logic [7:0] periph_out_en,
    input logic [7:0] periph_out_val,
    input logic       regulator_capacitor_en,
    input logic       crystal_output_en,
    input logic       crystal_output_val,
    input logic [7:0] digital_in,
    input logic [7:0] analog_connect
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RDY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_PHASE: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_ANA: assert property ((digital_in & analog_connect) == 8'h00)
        else $error("analog pin reads one");
    AST_RST: assert property ($rose(presetn) |=> analog_connect == 8'hFF)
        else $error("analog select not set after reset");
    AST_P6_CAP: assert property (regulator_capacitor_en |=> !pin_oe[6])
        else $error("pin six driven with capacitor");
    AST_P6_XO: assert property (!regulator_capacitor_en && crystal_output_en
        |=> pin_oe[6] && pin_out[6] == $past(crystal_output_val))
        else $error("pin six not crystal");
    AST_PER: assert property (periph_out_en[0] |=> pin_oe[0]
        && pin_out[0] == $past(periph_out_val[0]))
        else $error("peripheral lost pin zero");
endmodule
bind bpa_port bpa_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .pin_out, .pin_oe, .periph_out_en, .periph_out_val,
    .regulator_capacitor_en, .crystal_output_en, .crystal_output_val,
    .digital_in, .analog_connect);

// File: verif/bpa_port_tb.sv
// Self-checking bench for the analog-select GPIO port
`timescale 1ns/100ps
module bpa_port_tb;
    typedef struct packed {
        logic [11:0] a;
        logic        w;
        logic [3:0]  s;
        logic [7:0]  d;
        logic [7:0]  e;
        logic        r;
    } bpa_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  pin_in, pin_out, pin_oe, periph_out_en, periph_out_val;
    logic [7:0]  digital_in, analog_connect;
    logic        regulator_capacitor_en, crystal_output_en, crystal_output_val;
    logic        clock_output_pin_en, clock_output_pin_val;
    logic        lcd_segment_one_en, lcd_segment_one_val;
    int          n_errors, n_tests, i;
    logic [1:0]  p6 [4] = '{2'b11, 2'b10, 2'b11, 2'b00};
    bpa_row_t    rows [12] = '{
        '{12'h004, 1'b0, 4'h0, 8'h00, 8'hFF, 1'b0},
        '{12'h008, 1'b0, 4'h0, 8'h00, 8'h00, 1'b0},
        '{12'h00C, 1'b0, 4'h0, 8'h00, 8'hFF, 1'b0},
        '{12'h00C, 1'b1, 4'h1, 8'h00, 8'h00, 1'b0},
        '{12'h008, 1'b1, 4'h1, 8'hA5, 8'h00, 1'b0},
        '{12'h004, 1'b1, 4'h1, 8'hF0, 8'h00, 1'b0},
        '{12'h000, 1'b0, 4'h0, 8'h00, 8'h35, 1'b0},
        '{12'h000, 1'b1, 4'h0, 8'h00, 8'h00, 1'b0},
        '{12'h008, 1'b0, 4'h0, 8'h00, 8'h35, 1'b0},
        '{12'h00C, 1'b1, 4'h1, 8'h0F, 8'h00, 1'b0},
        '{12'h000, 1'b0, 4'h0, 8'h00, 8'h30, 1'b0},
        '{12'h010, 1'b0, 4'h0, 8'h00, 8'h00, 1'b1}};
    bpa_port #(.WIDTH(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in,
        .pin_out, .pin_oe, .periph_out_en, .periph_out_val,
        .regulator_capacitor_en, .crystal_output_en, .crystal_output_val,
        .clock_output_pin_en, .clock_output_pin_val, .lcd_segment_one_en,
        .lcd_segment_one_val, .digital_in, .analog_connect);
    bpa_pin_model u_ext (.pin_out, .pin_oe, .ext_val(8'h3C), .pin_in);
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x)
        begin
            n_errors++;
            $display("unexpected at %0t got %h expected %h", $time, g, x);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task apb(input bpa_row_t r);
        psel <= 1'b1;
        paddr <= r.a;
        pwrite <= r.w;
        pstrb <= r.s;
        pwdata <= {24'h00_0000, r.d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask
    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
        {periph_out_en, periph_out_val, regulator_capacitor_en} = '0;
        {crystal_output_en, crystal_output_val, clock_output_pin_en} = '0;
        {clock_output_pin_val, lcd_segment_one_en, lcd_segment_one_val} = '0;
        do_reset();
        chk(32'(analog_connect), 32'h0000_00FF);
        for (i = 0; i < 12; i++)
        begin
            apb(rows[i]);
            chk(rd, {24'h00_0000, rows[i].e});
            chk(32'(er), 32'(rows[i].r));
            repeat (4) @(posedge pclk);
        end
        chk(32'(pin_oe), 32'h0000_000F);
        chk(32'(pin_out & 8'h0F), 32'h0000_0005);
        chk(32'(analog_connect), 32'h0000_000F);
        chk(32'(digital_in), 32'h0000_0030);
        periph_out_en <= 8'h41;
        {crystal_output_val, lcd_segment_one_val} <= 2'b11;
        for (i = 0; i < 4; i++)
        begin
            {regulator_capacitor_en, crystal_output_en, clock_output_pin_en,
                lcd_segment_one_en} <= 4'(15 >> (3 - i));
            repeat (2) @(posedge pclk);
            chk(32'({pin_oe[6], pin_out[6] & pin_oe[6]}), 32'(p6[i]));
        end
        chk(32'({pin_oe[0], pin_out[0]}), 32'h0000_0002);
        {periph_out_en, regulator_capacitor_en, crystal_output_en} <= '0;
        {clock_output_pin_en, lcd_segment_one_en} <= '0;
        do_reset();
        chk(32'({analog_connect, pin_oe}), 32'h0000_FF00);
        report_and_stop();
    end
endmodule
